// ### rtl/aodr_pkg.sv
/*
 Constants, field layout and helpers of the diagnostic record of a
 four-channel analog output module.
 Assumes one 100 MHz system clock and fault sources on that same clock.
// What this block does
// - Extended error byte: overflow bit 3, comm bit 4
// - Channel type byte reads analog output 73h
// - Diagnostic bits per channel reads eight
// - Channel count byte reads four
// - Group error bit n for channel group n
// - Fault byte bit 0: parameter error
// - Fault byte bit 3: short to ground
// - Timestamp holds ticker value at diagnostic event
// - Microsecond ticker starts at zero, counts microseconds
// - Ticker wraps to zero after 32-bit maximum
// - Primary diagnostic bit 3 on any channel error
*/
`default_nettype none

package aodr_pkg;

   // ===========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_PERIOD_NS = 1000;
   localparam int CYCLES_PER_US = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] PRESCALE_MAX = 7'(CYCLES_PER_US - 1);
   localparam logic [31:0] TICKER_MAX = 32'hFFFFFFFF;
   localparam logic [31:0] TICKER_RESET = 32'h00000000;

   // ===========================================================
   // Record byte indexes
   localparam int NUM_CHANNELS = 4;
   localparam logic [4:0] RECORD_LEN = 5'h14;
   localparam logic [4:0] IDX_PRIMARY = 5'h00;
   localparam logic [4:0] IDX_MODULE_INFO = 5'h01;
   localparam logic [4:0] IDX_RESERVED_C = 5'h02;
   localparam logic [4:0] IDX_EXT_ERR = 5'h03;
   localparam logic [4:0] IDX_CHTYPE = 5'h04;
   localparam logic [4:0] IDX_DIAG_BITS = 5'h05;
   localparam logic [4:0] IDX_CHAN_COUNT = 5'h06;
   localparam logic [4:0] IDX_GROUP_ERR = 5'h07;
   localparam logic [4:0] IDX_CHAN0_FAULT = 5'h08;
   localparam logic [4:0] IDX_UNUSED_FIRST = 5'h0C;
   localparam logic [4:0] IDX_UNUSED_LAST = 5'h0F;
   localparam logic [4:0] IDX_STAMP0 = 5'h10;

   // ===========================================================
   // Fixed values and reset values
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] MODULE_INFO_VAL = 8'h15;
   localparam logic [7:0] CHTYPE_ANALOG_OUT = 8'h73;
   localparam logic [7:0] DIAG_BITS_VAL = 8'h08;
   localparam logic [7:0] CHAN_COUNT_VAL = 8'h04;

   // ===========================================================
   // Bit positions
   localparam int PRIM_CHAN_ERR_BIT = 3;
   localparam int PRIM_PARAM_ERR_BIT = 7;
   localparam int EXT_OVF_BIT = 3;
   localparam int EXT_COMM_BIT = 4;
   localparam int CHF_PARAM_BIT = 0;
   localparam int CHF_SHORT_BIT = 3;

   // ===========================================================
   // Helpers
   function automatic logic [7:0] aodr_chan_fault(input logic param, input logic short_gnd);
      logic [7:0] b;
      b = BYTE_ZERO;
      b[CHF_PARAM_BIT] = param;
      b[CHF_SHORT_BIT] = short_gnd;
      return b;
   endfunction : aodr_chan_fault

endpackage : aodr_pkg

`default_nettype wire

// ### rtl/aodr_record.sv
/*
 Diagnostic record of a four-channel analog output module, read byte by
 byte through a record read port.
 Assumes fault inputs come from logic on sys_clk, so they are not
 synchronised, and that the reader samples rd_data on rd_valid.
*/
`timescale 1ns/1ps
`default_nettype none

module aodr_record
   import aodr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Fault sources, levels
   input wire logic [3:0] param_err_in,
   input wire logic [3:0] short_gnd_in,
   input wire logic diag_ovf_in,
   input wire logic comm_err_in,
   // Record read port
   input wire logic rd_en,
   input wire logic [4:0] rd_index,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // Status
   output logic chan_err_any,
   output logic [31:0] ticker_us
);

   typedef struct packed {
      logic [3:0] param;
      logic [3:0] short_gnd;
      logic ovf;
      logic comm;
      logic [31:0] stamp;
      logic [7:0] rd_data;
      logic rd_valid;
   } aodr_state_t;

   aodr_state_t state_reg;
   aodr_state_t state_next;
   logic [31:0] us_count;
   logic [9:0] new_faults;
   logic [3:0] group_err;

   // ===========================================================
   // Ticker
   aodr_ticker u_ticker (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .us_count(us_count)
   );

   // ===========================================================
   // Record decode
   function automatic logic [3:0] group_flags(input aodr_state_t s);
      logic [3:0] g;
      g = s.param | s.short_gnd;
      return g;
   endfunction : group_flags

   function automatic logic [7:0] record_byte(input logic [4:0] idx, input aodr_state_t s);
      logic [7:0] b;
      logic [3:0] g;
      b = BYTE_ZERO;
      g = group_flags(s);
      if (idx == IDX_PRIMARY)
      begin
         b[PRIM_CHAN_ERR_BIT] = |g;
         b[PRIM_PARAM_ERR_BIT] = |s.param;
      end
      else if (idx == IDX_MODULE_INFO)
      begin
         b = MODULE_INFO_VAL;
      end
      else if (idx == IDX_EXT_ERR)
      begin
         b[EXT_OVF_BIT] = s.ovf;
         b[EXT_COMM_BIT] = s.comm;
      end
      else if (idx == IDX_CHTYPE)
      begin
         b = CHTYPE_ANALOG_OUT;
      end
      else if (idx == IDX_DIAG_BITS)
      begin
         b = DIAG_BITS_VAL;
      end
      else if (idx == IDX_CHAN_COUNT)
      begin
         b = CHAN_COUNT_VAL;
      end
      else if (idx == IDX_GROUP_ERR)
      begin
         b[3:0] = g;
      end
      else if (idx >= IDX_CHAN0_FAULT && idx < IDX_UNUSED_FIRST)
      begin
         b = aodr_chan_fault(s.param[idx[1:0]], s.short_gnd[idx[1:0]]);
      end
      else if (idx >= IDX_STAMP0 && idx < RECORD_LEN)
      begin
         // Least significant byte first
         b = s.stamp[8 * idx[1:0] +: 8];
      end
      return b;
   endfunction : record_byte

   // ===========================================================
   // Next state
   always_comb
   begin
      state_next = state_reg;
      new_faults = {param_err_in, short_gnd_in, diag_ovf_in, comm_err_in}
         & ~{state_reg.param, state_reg.short_gnd, state_reg.ovf, state_reg.comm};
      state_next.param = param_err_in;
      state_next.short_gnd = short_gnd_in;
      state_next.ovf = diag_ovf_in;
      state_next.comm = comm_err_in;
      // Only a newly raised fault is a diagnostic event; a standing one keeps the first stamp
      if (|new_faults)
      begin
         state_next.stamp = us_count;
      end
      state_next.rd_valid = rd_en;
      if (rd_en)
      begin
         state_next.rd_data = record_byte(rd_index, state_reg);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= '0;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
      end
   end

   assign group_err = group_flags(state_reg);
   assign rd_data = state_reg.rd_data;
   assign rd_valid = state_reg.rd_valid;
   assign chan_err_any = |group_err;
   assign ticker_us = us_count;

   // ===========================================================
   // Checks
   sequence s_read(logic [4:0] idx);
      clk_en && rd_en && rd_index == idx;
   endsequence

   property p_ovf_bit;
      @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && diag_ovf_in) ##1 s_read(IDX_EXT_ERR) |=> (rd_valid && rd_data[EXT_OVF_BIT]);
   endproperty
   a_ovf_bit: assert property (p_ovf_bit) else $error("overflow bit not reported");

   property p_comm_bit;
      @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && !comm_err_in) ##1 s_read(IDX_EXT_ERR) |=> (rd_valid && !rd_data[EXT_COMM_BIT]);
   endproperty
   a_comm_bit: assert property (p_comm_bit) else $error("comm bit reported without error");

   property p_chtype;
      @(posedge sys_clk) disable iff (sys_rst)
      s_read(IDX_CHTYPE) |=> (rd_valid && rd_data == CHTYPE_ANALOG_OUT);
   endproperty
   a_chtype: assert property (p_chtype) else $error("wrong channel type");

   property p_bits_count;
      @(posedge sys_clk) disable iff (sys_rst)
      s_read(IDX_DIAG_BITS) |=> (rd_data == DIAG_BITS_VAL);
   endproperty
   a_bits_count: assert property (p_bits_count) else $error("wrong diagnostic bit count");

   property p_chan_count;
      @(posedge sys_clk) disable iff (sys_rst)
      s_read(IDX_CHAN_COUNT) |=> (rd_data == CHAN_COUNT_VAL);
   endproperty
   a_chan_count: assert property (p_chan_count) else $error("wrong channel count");

   property p_group_follow;
      @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && !(|(param_err_in | short_gnd_in))) |=> !chan_err_any;
   endproperty
   a_group_follow: assert property (p_group_follow) else $error("group error without fault");

   property p_short_bit;
      @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && short_gnd_in[2]) ##1 s_read(IDX_CHAN0_FAULT + 5'h02) |=> rd_data[CHF_SHORT_BIT];
   endproperty
   a_short_bit: assert property (p_short_bit) else $error("short bit missing in channel 2");

   property p_param_bit;
      @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && param_err_in[0]) |=> (state_reg.param[0] && chan_err_any);
   endproperty
   a_param_bit: assert property (p_param_bit) else $error("parameter error not held");

   property p_stamp;
      @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && |new_faults) |=> (state_reg.stamp == $past(us_count));
   endproperty
   a_stamp: assert property (p_stamp) else $error("timestamp not captured at event");

   property p_primary;
      @(posedge sys_clk) disable iff (sys_rst)
      s_read(IDX_PRIMARY) |=> (rd_data[PRIM_CHAN_ERR_BIT] == $past(chan_err_any));
   endproperty
   a_primary: assert property (p_primary) else $error("primary channel error bit wrong");

endmodule : aodr_record

`default_nettype wire

// ### rtl/aodr_ticker.sv
/*
 Free-running microsecond ticker for the diagnostic record.
 Assumes sys_rst is asserted at power-on; the count then starts at zero.
*/
`timescale 1ns/1ps
`default_nettype none

module aodr_ticker
   import aodr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Count
   output logic [31:0] us_count
);

   typedef struct packed {
      logic [6:0] prescale;
      logic [31:0] count;
   } aodr_tick_state_t;

   aodr_tick_state_t state_reg;
   aodr_tick_state_t state_next;

   // ===========================================================
   // Counting
   always_comb
   begin
      state_next = state_reg;
      if (state_reg.prescale == PRESCALE_MAX)
      begin
         state_next.prescale = 7'h00;
         // Natural 32-bit overflow gives the wrap to zero
         state_next.count = state_reg.count + 32'h00000001;
      end
      else
      begin
         state_next.prescale = state_reg.prescale + 7'h01;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= '0;
      end
      else if (clk_en)
      begin
         state_reg <= state_next;
      end
   end

   assign us_count = state_reg.count;

   // ===========================================================
   // Checks
   property p_tick_wrap;
      @(posedge sys_clk) disable iff (sys_rst)
      (clk_en && state_reg.prescale == PRESCALE_MAX && state_reg.count == TICKER_MAX) |=> (us_count == TICKER_RESET);
   endproperty
   a_tick_wrap: assert property (p_tick_wrap) else $error("ticker did not wrap to zero");

   // A step is only legal at the end of a full prescale period, and restarts it
   property p_tick_rate;
      @(posedge sys_clk) disable iff (sys_rst)
      $changed(us_count) |-> ($past(state_reg.prescale) == PRESCALE_MAX && state_reg.prescale == 7'h00);
   endproperty
   a_tick_rate: assert property (p_tick_rate) else $error("ticker stepped before a full microsecond");

   property p_tick_step;
      @(posedge sys_clk) disable iff (sys_rst)
      $changed(us_count) |-> (us_count == $past(us_count) + 32'h00000001);
   endproperty
   a_tick_step: assert property (p_tick_step) else $error("ticker stepped by other than one");

endmodule : aodr_ticker

`default_nettype wire

// ### tb/aodr_reader.sv
/*
 Reader model: the coupler side that fetches record bytes one at a time.
 Assumes the bench calls req and idle; signals change at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module aodr_reader (
   // Clock
   input wire logic sys_clk,
   // Record read request
   output logic rd_en,
   output logic [4:0] rd_index
);
   initial
   begin
      rd_en = 1'b0;
      rd_index = 5'h00;
   end

   // Held high between calls, so back-to-back reads never glitch low
   task automatic req(input logic [4:0] idx);
      @(negedge sys_clk);
      rd_en = 1'b1;
      rd_index = idx;
   endtask : req

   // Stale index is inverted so nothing can lean on its old value
   task automatic idle();
      @(negedge sys_clk);
      rd_en = 1'b0;
      rd_index = ~rd_index;
   endtask : idle
endmodule : aodr_reader

`default_nettype wire

// ### tb/aodr_record_tb.sv
/*
 Self-checking bench of the diagnostic record.
 Assumes aodr_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module aodr_record_tb
   import aodr_pkg::*;
;
   logic sys_clk, sys_rst, clk_en, diag_ovf_in, comm_err_in, rd_en, rd_valid, chan_err_any;
   logic [3:0] param_err_in, short_gnd_in, p, s;
   logic [4:0] rd_index;
   logic [7:0] rd_data;
   logic [31:0] ticker_us, t;
   logic [12:0] q[$];
   logic [12:0] e;
   int err_total = 0;
   int n_compared = 0;

   aodr_record u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .param_err_in(param_err_in), .short_gnd_in(short_gnd_in), .diag_ovf_in(diag_ovf_in),
      .comm_err_in(comm_err_in), .rd_en(rd_en), .rd_index(rd_index), .rd_data(rd_data),
      .rd_valid(rd_valid), .chan_err_any(chan_err_any), .ticker_us(ticker_us));
   aodr_reader u_rd (.sys_clk(sys_clk), .rd_en(rd_en), .rd_index(rd_index));

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ==========================================================
   // Checking
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic rd(input logic [4:0] idx, input logic [7:0] exp);
      u_rd.req(idx);
      q.push_back({idx, exp});
   endtask : rd

   // Each answered read retires the oldest note
   always @(negedge sys_clk)
      if (rd_valid === 1'b1)
      begin
         if (q.size() == 0)
            chk("rd_valid", 32'h0, 32'h1);
         else
         begin
            e = q.pop_front();
            chk($sformatf("byte %0d", e[12:8]), {24'h0, e[7:0]}, {24'h0, rd_data});
         end
      end

   // ==========================================================
   // Stimulus
   initial
   begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      {param_err_in, short_gnd_in, diag_ovf_in, comm_err_in} = 10'h000;
      void'($urandom(35));
      repeat (10) @(negedge sys_clk);
      sys_rst = 1'b0;
      chk("ticker_us", 32'h0, ticker_us);
      for (int i = 0; i < 32; i++)
         if (i < 16 || i > 19)
            rd(5'(i), i == 1 ? 8'h15 : i == 4 ? 8'h73 : i == 5 ? 8'h08 : i == 6 ? 8'h04 : 8'h00);
      u_rd.idle();
      for (int k = 0; k < 8; k++)
      begin
         @(negedge sys_clk);
         p = 4'($urandom);
         s = 4'($urandom);
         param_err_in = p;
         short_gnd_in = s;
         diag_ovf_in = k[0];
         comm_err_in = k[1];
         rd(IDX_PRIMARY, {|p, 3'b000, |(p | s), 3'b000});
         chk("chan_err_any", {31'h0, |(p | s)}, {31'h0, chan_err_any});
         rd(IDX_EXT_ERR, {3'b000, k[1], k[0], 3'b000});
         rd(IDX_GROUP_ERR, {4'h0, p | s});
         for (int n = 0; n < 4; n++)
            rd(IDX_CHAN0_FAULT + 5'(n), {4'h0, s[n], 2'b00, p[n]});
         u_rd.idle();
      end
      @(negedge sys_clk);
      {param_err_in, short_gnd_in, diag_ovf_in, comm_err_in} = 10'h000;
      repeat (150) @(negedge sys_clk);
      t = ticker_us;
      short_gnd_in[2] = 1'b1;
      // Standing fault must not restamp while the ticker moves on
      repeat (250) @(negedge sys_clk);
      for (int b = 0; b < 4; b++)
         rd(IDX_STAMP0 + 5'(b), t[8 * b +: 8]);
      u_rd.idle();
      t = ticker_us;
      repeat (100) @(negedge sys_clk);
      chk("ticker_us", t + 32'h1, ticker_us);
      clk_en = 1'b0;
      t = ticker_us;
      u_rd.req(IDX_CHTYPE);
      u_rd.idle();
      repeat (20) @(negedge sys_clk);
      chk("frozen ticker_us", t, ticker_us);
      clk_en = 1'b1;
      for (int w = 0; w < 10 && q.size() > 0; w++)
         @(negedge sys_clk);
      if (q.size() > 0)
         chk("pending reads", 32'h0, q.size());
      stop_test();
   end

   initial
   begin
      #500us;
      chk("timeout", 32'h0, 32'h1);
      stop_test();
   end
endmodule : aodr_record_tb

`default_nettype wire
